//--- hsl_top.sv
/*
  reset-time strap capture, indicator polarity and port power polarity of a seven-port hub.
  assumes an apb master on pclk, board pull resistors on the shared indicator pins,
  and external power switches and current monitors.
*/
// The placing of the registers and the APB register port are this design's own decisions.
// What this block does
// - straps other than polarity count only when config selects read high then low
// - disable code 00: all ports on, green 4 and 3 active high
// - codes 01/10/11 disable 7, 7-6, 7-5; bits set green 4/3 active low
// - sample straps at reset release; they set port attributes and led polarity
// - fixed-device code 00: all removable, green 2 and 1 active high
// - codes 01/10/11 fix port 1, 1-2, 1-3; bits set green 2/1 active low
// - external config with leds enabled drives green 4..1 active low
// - amber 7, 6, 5 always active low
// - amber 3 always active low
// - external config with leds enabled drives amber 4, 2, 1 active low
// - indicator strap 0 leaves amber 4 idle, other leds still driven; 1 enables amber 4, active low
// - translator strap 0 single, amber 2 high; 1 multiple, amber 2 low
// - gang strap 0: per-port power and sensing, amber 1 active high
// - gang strap 1: ganged power and sensing, amber 1 active low
// - during reset power enables follow the polarity pin, all ports off
// - polarity is latched at reset release and kept until next reset
// - latched polarity 0 gives active-low power enables, 1 active-high
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.svh"

module hsl_top (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         config_select_high,
  input  wire logic         config_select_low,
  input  wire logic         power_polarity_strap,
  input  wire logic [7:1]   green_indicator_i,
  output logic      [7:1]   green_indicator_o,
  output logic      [7:1]   green_indicator_oe,
  input  wire logic [7:1]   amber_indicator_i,
  output logic      [7:1]   amber_indicator_o,
  output logic      [7:1]   amber_indicator_oe,
  input  wire logic [7:1]   overcurrent_sense_n,
  output logic      [7:1]   port_power_enable
);
  import hsl_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisation
  // --------------------------------------------------------------------------
  logic [`HSL_SYNC_W-1:0] raw;
  logic [`HSL_SYNC_W-1:0] syn;

  assign raw = {config_select_high, config_select_low, power_polarity_strap,
                amber_indicator_i[4], amber_indicator_i[2], amber_indicator_i[1],
                green_indicator_i[4:1], overcurrent_sense_n};

  hsl_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (raw),
    .dout    (syn)
  );

  // --------------------------------------------------------------------------
  // strap capture sequence
  // --------------------------------------------------------------------------
  hsl_state_t  state_q;
  hsl_state_t  state_d;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  hsl_straps_t straps_q;
  hsl_straps_t straps_d;
  logic        run;

  assign run = (state_q == ST_RUN);

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    straps_d = straps_q;
    case (state_q)
      ST_WAIT:
      begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == `HSL_SETTLE_CYC)
        begin
          state_d = ST_TAKE;
        end
      end
      ST_TAKE:
      begin
        // capture once after release; pins still inputs here
        straps_d.cfg  = syn[16:15];
        straps_d.pol  = syn[14];
        straps_d.led  = syn[13];
        straps_d.mtt  = syn[12];
        straps_d.gang = syn[11];
        straps_d.pd   = syn[10:9];
        straps_d.fx   = syn[8:7];
        state_d       = ST_RUN;
      end
      default:
      begin
        // nothing moves the straps until the next reset
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= ST_WAIT;
      cnt_q    <= 3'h0;
      straps_q <= '0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      straps_q <= straps_d;
    end
  end

  // --------------------------------------------------------------------------
  // effective configuration
  // --------------------------------------------------------------------------
  logic [6:0] cfg_q;
  logic [6:0] cfg_d;
  logic [7:1] pwr_req_q;
  logic [7:1] pwr_req_d;
  logic [15:0] led_on_q;
  logic [15:0] led_on_d;
  logic       strap_mode;
  logic [1:0] pd;
  logic [1:0] fx;
  logic       indicator_enable_strap;
  logic       multi_translator_strap;
  logic       gang_en;
  logic [7:1] port_en;
  logic [7:1] fixed;
  logic [7:1] oc;
  logic       oc_any;

  // straps other than polarity apply only under internal default configuration
  assign strap_mode = (straps_q.cfg == `HSL_CFG_STRAPS);
  assign pd      = strap_mode ? straps_q.pd   : cfg_q[`HSL_F_PD +: 2];
  assign fx      = strap_mode ? straps_q.fx   : cfg_q[`HSL_F_FX +: 2];
  assign indicator_enable_strap  = strap_mode ? straps_q.led  : cfg_q[`HSL_F_LED];
  assign multi_translator_strap  = strap_mode ? straps_q.mtt  : cfg_q[`HSL_F_MTT];
  assign gang_en = strap_mode ? straps_q.gang : cfg_q[`HSL_F_GANG];
  // low on the sense input reports an overcurrent
  assign oc      = ~syn[6:0];
  assign oc_any  = |(oc & port_en);

  // --------------------------------------------------------------------------
  // per-port attributes, power and indicators
  // --------------------------------------------------------------------------
  logic [7:1] pwr_on;
  logic [7:1] green_low;
  logic [7:1] amber_low;
  logic [7:1] green_drv;
  logic [7:1] amber_drv;
  logic [7:1] ppe_d;
  logic [7:1] ppe_q;
  logic [7:1] gr_o_d;
  logic [7:1] gr_oe_d;
  logic [7:1] am_o_d;
  logic [7:1] am_oe_d;

  genvar p;
  generate
    for (p = 1; p <= 7; p++)
    begin : g_port
      // code n disables the top n ports
      if (p >= 5)
      begin : g_hi
        assign port_en[p] = (pd < 2'(8 - p));
      end
      else
      begin : g_lo
        assign port_en[p] = 1'b1;
      end
      // code n fixes the bottom n ports
      if (p <= 3)
      begin : g_fx
        assign fixed[p] = (fx >= 2'(p));
      end
      else
      begin : g_nfx
        assign fixed[p] = 1'b0;
      end
      // ganged or per-port switching and sensing
      assign pwr_on[p] = port_en[p] & (gang_en ? (pwr_req_q[1] & ~oc_any)
                                               : (pwr_req_q[p] & ~oc[p]));
      // off level is the inverse of the latched active level
      assign ppe_d[p]   = pwr_on[p] ? straps_q.pol : ~straps_q.pol;
      assign gr_o_d[p]  = led_on_q[p] ^ green_low[p];
      assign am_o_d[p]  = led_on_q[`HSL_F_AMBER + p] ^ amber_low[p];
      // pins turn to outputs only after the capture
      assign gr_oe_d[p] = run & green_drv[p];
      assign am_oe_d[p] = run & amber_drv[p];
    end
  endgenerate

  always_comb
  begin
    // upper green and amber 7..5, 3 are fixed active low
    green_low = 7'h7F;
    amber_low = 7'h7F;
    green_drv = 7'h7F;
    amber_drv = 7'h7F;
    if (strap_mode)
    begin
      // sampled bits choose green 4..1 polarity
      green_low[4] = pd[1];
      green_low[3] = pd[0];
      green_low[2] = fx[1];
      green_low[1] = fx[0];
      // amber 4 idle when leds are off
      amber_drv[4] = indicator_enable_strap;
      amber_low[2] = multi_translator_strap;
      amber_low[1] = gang_en;
    end
    else
    begin
      // external config: 4..1 active low, driven only with leds on
      green_drv[4:1] = {4{indicator_enable_strap}};
      amber_drv[4]   = indicator_enable_strap;
      amber_drv[2:1] = {2{indicator_enable_strap}};
    end
  end

  // combinational from the pin until the latch is made
  assign port_power_enable = run ? ppe_q : {7{~power_polarity_strap}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ppe_q              <= 7'h00;
      green_indicator_o  <= 7'h00;
      green_indicator_oe <= 7'h00;
      amber_indicator_o  <= 7'h00;
      amber_indicator_oe <= 7'h00;
    end
    else
    begin
      ppe_q              <= ppe_d;
      green_indicator_o  <= gr_o_d;
      green_indicator_oe <= gr_oe_d;
      amber_indicator_o  <= am_o_d;
      amber_indicator_oe <= am_oe_d;
    end
  end

  // --------------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------------
  logic        acc;
  logic        rdy_d;
  logic [31:0] rd_d;
  logic        err_d;
  logic        mapped;
  logic [31:0] rd_word;

  assign acc   = psel & penable & pready;
  assign rdy_d = psel & penable & ~pready;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (paddr == `HSL_CFG_OFS)
    begin
      rd_word[6:0] = cfg_q;
    end
    else if (paddr == `HSL_STATUS_OFS)
    begin
      rd_word[`HSL_F_PD +: 2]     = pd;
      rd_word[`HSL_F_FX +: 2]     = fx;
      rd_word[`HSL_F_LED]         = indicator_enable_strap;
      rd_word[`HSL_F_MTT]         = multi_translator_strap;
      rd_word[`HSL_F_GANG]        = gang_en;
      rd_word[`HSL_F_POL]         = straps_q.pol;
      rd_word[`HSL_F_STRAPMODE]   = strap_mode;
      rd_word[`HSL_F_RUN]         = run;
      rd_word[`HSL_F_CFGSEL +: 2] = straps_q.cfg;
    end
    else if (paddr == `HSL_PORTS_OFS)
    begin
      rd_word[`HSL_F_PORTEN + 1 +: 7] = port_en;
      rd_word[`HSL_F_FIXED + 1 +: 7]  = fixed;
      rd_word[`HSL_F_OC + 1 +: 7]     = oc;
    end
    else if (paddr == `HSL_POWER_OFS)
    begin
      rd_word[7:1] = pwr_req_q;
    end
    else if (paddr == `HSL_LED_OFS)
    begin
      rd_word[15:0] = led_on_q;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  always_comb
  begin
    rd_d      = rdy_d ? (pwrite ? 32'h0000_0000 : rd_word) : prdata;
    err_d     = rdy_d ? ~mapped : 1'b0;
    cfg_d     = cfg_q;
    pwr_req_d = pwr_req_q;
    led_on_d  = led_on_q;
    if (acc && pwrite && !pslverr)
    begin
      if (paddr == `HSL_CFG_OFS)
      begin
        cfg_d = pwdata[6:0];
      end
      else if (paddr == `HSL_POWER_OFS)
      begin
        pwr_req_d = pwdata[7:1];
      end
      else if (paddr == `HSL_LED_OFS)
      begin
        led_on_d = {pwdata[15:9], 1'b0, pwdata[7:1], 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready    <= 1'b0;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
      cfg_q     <= `HSL_CFG_RST;
      pwr_req_q <= `HSL_PWR_RST;
      led_on_q  <= `HSL_LED_RST;
    end
    else
    begin
      pready    <= rdy_d;
      prdata    <= rd_d;
      pslverr   <= err_d;
      cfg_q     <= cfg_d;
      pwr_req_q <= pwr_req_d;
      led_on_q  <= led_on_d;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take;
    state_q == ST_TAKE;
  endsequence

  sequence s_settled;
    state_q == ST_RUN ##1 state_q == ST_RUN;
  endsequence

  a_capture_order: assert property (s_take |=> s_settled)
    else $error("capture did not lead into run");
  a_straps_hold: assert property (run && $past(run) |-> $stable(straps_q))
    else $error("straps moved after capture");
  a_power_reset: assert property (!run |-> port_power_enable == {7{~power_polarity_strap}})
    else $error("power enable not at off level before capture");
  a_power_off_level: assert property (run && $past(run) && !$past(pwr_on[7])
                                      |-> port_power_enable[7] == ~straps_q.pol)
    else $error("port 7 power not at off level");
  a_pd_three: assert property (strap_mode && pd == 2'h3 |-> port_en == 7'h0F)
    else $error("disable code 3 wrong port set");
  a_fixed_two: assert property (strap_mode && fx == 2'h2 |-> fixed == 7'h03)
    else $error("fixed code 2 wrong port set");
  a_amber3_low: assert property (run ##1 run |-> amber_indicator_o[3] == ~$past(led_on_q[11]))
    else $error("amber 3 not active low");
  a_ext_green: assert property (run && !strap_mode && indicator_enable_strap ##1 run
                                |-> green_indicator_oe[4:1] == 4'hF)
    else $error("green 4..1 not driven under external config");
  a_mtt_level: assert property (strap_mode && !multi_translator_strap |-> amber_low[2] == 1'b0)
    else $error("amber 2 polarity wrong for single translator");
  a_pins_input: assert property (state_q == ST_WAIT ##1 state_q != ST_RUN
                                 |-> green_indicator_oe == 7'h00 && amber_indicator_oe == 7'h00)
    else $error("indicator pins driven before capture");

endmodule

`default_nettype wire

//--- hsl_map.svh
/*
  register offsets, field positions, reset values and timing counts of the hub strap block.
  assumes a 32-bit apb slave with byte addresses, one aligned word per register.
*/
`ifndef HSL_MAP_SVH
`define HSL_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define HSL_CFG_OFS     8'h00
`define HSL_STATUS_OFS  8'h04
`define HSL_PORTS_OFS   8'h08
`define HSL_POWER_OFS   8'h0C
`define HSL_LED_OFS     8'h10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define HSL_F_PD        0
`define HSL_F_FX        2
`define HSL_F_LED       4
`define HSL_F_MTT       5
`define HSL_F_GANG      6
`define HSL_F_POL       7
`define HSL_F_STRAPMODE 8
`define HSL_F_RUN       9
`define HSL_F_CFGSEL    10
`define HSL_F_PORTEN    0
`define HSL_F_FIXED     8
`define HSL_F_OC        16
`define HSL_F_AMBER     8

// ----------------------------------------------------------------------------
// codes, reset values and counts
// ----------------------------------------------------------------------------
`define HSL_CFG_STRAPS  2'h2
`define HSL_CFG_RST     7'h00
`define HSL_PWR_RST     7'h00
`define HSL_LED_RST     16'h0000
`define HSL_SYNC_W      17
`define HSL_SETTLE_CYC  3'h4

`endif

//--- hsl_pkg.sv
/*
  types shared by the hub strap block.
  assumes hsl_map.svh for all numeric constants.
*/
package hsl_pkg;

  // gray coded along wait -> take -> run
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_TAKE = 2'b01,
    ST_RUN  = 2'b11
  } hsl_state_t;

  typedef struct packed {
    logic [1:0] cfg;
    logic       pol;
    logic       led;
    logic       mtt;
    logic       gang;
    logic [1:0] pd;
    logic [1:0] fx;
  } hsl_straps_t;

endpackage

//--- hsl_sync.sv
/*
  three flip-flop synchroniser with agreement filter.
  assumes inputs are asynchronous to pclk; output moves once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.svh"

module hsl_sync (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [`HSL_SYNC_W-1:0] din,
  output logic      [`HSL_SYNC_W-1:0] dout
);

  logic [`HSL_SYNC_W-1:0] s1_q;
  logic [`HSL_SYNC_W-1:0] s2_q;
  logic [`HSL_SYNC_W-1:0] s3_q;
  logic [`HSL_SYNC_W-1:0] out_d;

  always_comb
  begin
    for (int i = 0; i < `HSL_SYNC_W; i++)
    begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : dout[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= out_d;
    end
  end

endmodule

`default_nettype wire

//--- hsl_board.sv
/*
  board model of the hub strap block: strap pulls on the shared pins, current monitors.
  assumes the hub releases a shared pin (oe low) until it has taken the straps.
*/
`timescale 1ns/1ps
`default_nettype none

module hsl_board (
  input  wire logic [7:1] green_indicator_o,
  input  wire logic [7:1] green_indicator_oe,
  input  wire logic [7:1] amber_indicator_o,
  input  wire logic [7:1] amber_indicator_oe,
  input  wire logic [1:0] pd,
  input  wire logic [1:0] fx,
  input  wire logic       led,
  input  wire logic       mtt,
  input  wire logic       gang,
  input  wire logic [7:1] fault,
  output logic      [7:1] green_indicator_i,
  output logic      [7:1] amber_indicator_i,
  output logic      [7:1] overcurrent_sense_n
);
  // --------------------
  // shared pin levels
  // --------------------
  logic [7:1] g_pull;
  logic [7:1] a_pull;
  assign g_pull = {3'b111, pd, fx};
  assign a_pull = {3'b111, led, 1'b1, mtt, gang};
  assign green_indicator_i = (green_indicator_oe & green_indicator_o) | (~green_indicator_oe & g_pull);
  assign amber_indicator_i = (amber_indicator_oe & amber_indicator_o) | (~amber_indicator_oe & a_pull);
  // monitor pulls low on a fault, pull-up holds it idle otherwise
  assign overcurrent_sense_n = ~fault;
endmodule

`default_nettype wire

//--- hsl_top_tb.sv
/*
  testbench of the hub strap block: strap boots, indicator levels, power polarity, apb.
  assumes hsl_pkg, hsl_sync, hsl_top and hsl_board are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.svh"

module hsl_top_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        config_select_high = 1'b1;
  logic        config_select_low = 1'b0;
  logic        power_polarity_strap = 1'b0;
  logic [7:1]  green_indicator_i, green_indicator_o, green_indicator_oe;
  logic [7:1]  amber_indicator_i, amber_indicator_o, amber_indicator_oe;
  logic [7:1]  overcurrent_sense_n, port_power_enable;
  logic [7:1]  fault = 7'h00;
  logic [1:0]  pd = 2'b00;
  logic [1:0]  fx = 2'b00;
  logic        led = 1'b0;
  logic        mtt = 1'b0;
  logic        gang = 1'b0;
  logic        pol_l = 1'b0;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #12.5 pclk = ~pclk;

  hsl_top hsl_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .config_select_high, .config_select_low, .power_polarity_strap,
    .green_indicator_i, .green_indicator_o, .green_indicator_oe,
    .amber_indicator_i, .amber_indicator_o, .amber_indicator_oe,
    .overcurrent_sense_n, .port_power_enable
  );

  hsl_board hsl_board_inst (
    .green_indicator_o, .green_indicator_oe, .amber_indicator_o, .amber_indicator_oe,
    .pd, .fx, .led, .mtt, .gang, .fault,
    .green_indicator_i, .amber_indicator_i, .overcurrent_sense_n
  );

  // --------------------
  // shared tasks
  // --------------------
  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      n_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] rd);
    logic er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
  endtask

  function automatic logic [6:0] en_m();
    return 7'h7F >> pd;
  endfunction

  function automatic logic [6:0] fix_m();
    return (7'h01 << fx) - 7'h01;
  endfunction

  // --------------------
  // scenarios
  // --------------------
  task automatic boot(input logic [1:0] p, input logic [1:0] f, input logic l,
                      input logic m, input logic g, input logic o);
    logic [31:0] rd;
    int          n;
    n = 0;
    rd = 32'h0000_0000;
    presetn <= 1'b0;
    {config_select_high, config_select_low} <= 2'b10;
    {pd, fx, led, mtt, gang, fault} <= {p, f, l, m, g, 7'h00};
    power_polarity_strap <= ~o;
    pol_l = o;
    repeat (2) @(posedge pclk);
    chk(32'(port_power_enable), 32'({7{o}}));
    power_polarity_strap <= o;
    repeat (10) @(posedge pclk);
    chk(32'(port_power_enable), 32'({7{~o}}));
    presetn <= 1'b1;
    while (rd[9] !== 1'b1 && n < 20)
    begin
      rdr(`HSL_STATUS_OFS, rd);
      n++;
    end
    chk(32'(rd[11:0]), 32'({4'b1011, o, g, m, l, f, p}));
    rdr(`HSL_PORTS_OFS, rd);
    chk(32'(rd[23:0]), 32'({8'h00, fix_m(), 1'b0, en_m(), 1'b0}));
  endtask

  task automatic chk_pins(input logic on);
    wr(`HSL_LED_OFS, on ? 32'h0000_FEFE : 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(green_indicator_o), 32'({3'b111, pd, fx} ^ {7{on}}));
    chk(32'(green_indicator_oe), 32'h0000_007F);
    chk(32'({amber_indicator_o[7:5], amber_indicator_o[3:1]}),
        32'({4'b1111, mtt, gang} ^ {6{on}}));
    chk(32'(amber_indicator_oe), 32'({3'b111, led, 3'b111}));
    if (led)
      chk(32'(amber_indicator_o[4]), 32'({~on}));
  endtask

  task automatic hold_check();
    logic [31:0] r0;
    logic [31:0] r1;
    rdr(`HSL_STATUS_OFS, r0);
    config_select_low <= 1'b1;
    power_polarity_strap <= ~pol_l;
    repeat (10) @(posedge pclk);
    rdr(`HSL_STATUS_OFS, r1);
    chk(r1, r0);
  endtask

  task automatic power_check();
    logic [6:0] on;
    wr(`HSL_POWER_OFS, 32'h0000_00FE);
    repeat (4) @(posedge pclk);
    on = pol_l ? en_m() : ~en_m();
    chk(32'(port_power_enable), 32'(on));
    fault <= 7'h01;
    repeat (12) @(posedge pclk);
    on = gang ? 7'h00 : (en_m() & 7'h7E);
    on = pol_l ? on : ~on;
    chk(32'(port_power_enable), 32'(on));
    fault <= 7'h00;
    wr(`HSL_POWER_OFS, 32'h0000_0000);
  endtask

  task automatic ext_cfg();
    logic [31:0] rd;
    presetn <= 1'b0;
    config_select_low <= 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    wr(`HSL_CFG_OFS, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    rdr(`HSL_STATUS_OFS, rd);
    chk(32'(rd[8]), 32'h0000_0000);
    rdr(`HSL_PORTS_OFS, rd);
    chk(32'(rd[7:1]), 32'h0000_007F);
    chk(32'({green_indicator_oe[4:1], green_indicator_o[4:1]}), 32'h0000_00FF);
    chk(32'({amber_indicator_oe[4], amber_indicator_oe[2:1], amber_indicator_o[4],
             amber_indicator_o[2:1]}), 32'h0000_003F);
    wr(`HSL_CFG_OFS, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'({green_indicator_oe[4:1], amber_indicator_oe[4], amber_indicator_oe[2:1]}),
        32'h0000_0000);
  endtask

  task automatic bad_addr();
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, rd, er);
    chk(32'(er), 32'h0000_0001);
    apb(1'b0, 8'h14, 32'h0000_0000, rd, er);
    chk({rd[30:0], er}, 32'h0000_0001);
  endtask

  // --------------------
  // main sequence
  // --------------------
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      boot(i[1:0], ~i[1:0], i[0], i[1], ~i[0], i[0] ^ i[1]);
      chk_pins(1'b0);
      chk_pins(1'b1);
      hold_check();
      power_check();
    end
    ext_cfg();
    bad_addr();
    give_verdict();
  end
endmodule

`default_nettype wire
